// file: rtl/pco_pkg.sv
// constants for the position compare output slots 13 to 16
package pco_pkg;

  localparam int          PCO_SLOTS      = 4;
  localparam int          PCO_ADDR_W     = 16;
  localparam int          PCO_IDX_W      = 14;

  // register indices; byte address is four times the index
  localparam logic [13:0] PCO_TGT_IDX [PCO_SLOTS] = '{14'h1924, 14'h1927, 14'h192a, 14'h192d};
  localparam logic [13:0] PCO_ATTR_IDX [PCO_SLOTS] = '{14'h1926, 14'h1929, 14'h192c, 14'h192f};
  localparam logic [13:0] PCO_STAT_IDX   = 14'h1940;

  // attribute field positions
  localparam int          PCO_B_RISE     = 0;
  localparam int          PCO_B_FALL     = 1;
  localparam int          PCO_B_OUT1     = 7;
  localparam int          PCO_B_OUT2     = 8;
  localparam int          PCO_B_DIVA     = 12;
  localparam int          PCO_B_DIVZ     = 13;
  localparam int          PCO_B_OCZ [PCO_SLOTS] = '{15, 14, 14, 14};

  // reset values
  localparam logic [31:0] PCO_TGT_RST    = 32'h0000_0000;
  localparam logic [15:0] PCO_ATTR_RST   = 16'h0000;

endpackage

// file: rtl/pco_compare.sv
// position compare slots 13 to 16 with register port and routed event outputs
`timescale 1ns/1ps
module pco_compare
  import pco_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic [PCO_ADDR_W-1:0] addr,
  input  wire logic [31:0]           wr_data,
  input  wire logic                  wr_strobe,
  input  wire logic                  rd_strobe,
  output logic      [31:0]           rd_data,
  input  wire logic signed [31:0]    pos_value,
  input  wire logic                  pos_valid,
  output logic                       first_general_output,
  output logic                       second_general_output,
  output logic                       freq_div_a_output,
  output logic                       freq_div_z_output,
  output logic                       open_collector_index_output
);

  logic signed [31:0]   target_reg [PCO_SLOTS];
  logic        [15:0]   attr_reg   [PCO_SLOTS];
  logic [PCO_SLOTS-1:0] above_reg;
  logic [PCO_SLOTS-1:0] known_reg;
  logic [PCO_SLOTS-1:0] rise_hit;
  logic [PCO_SLOTS-1:0] fall_hit;
  logic [PCO_SLOTS-1:0] ev;
  logic [PCO_SLOTS-1:0] ev_out1;
  logic [PCO_SLOTS-1:0] ev_out2;
  logic [PCO_SLOTS-1:0] ev_diva;
  logic [PCO_SLOTS-1:0] ev_divz;
  logic [PCO_SLOTS-1:0] ev_ocz;
  logic [31:0]          rd_data_reg;
  logic [31:0]          rd_data_next;
  logic [PCO_IDX_W-1:0] idx;
  logic                 aligned;

  assign idx     = addr[PCO_ADDR_W-1:2];
  assign aligned = (addr[1:0] == 2'h0);

  //////////////////////////////////////////////////////////////////////////////
  // register writes

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      for (int i = 0; i < PCO_SLOTS; i++)
      begin
        target_reg[i] <= PCO_TGT_RST;
        attr_reg[i]   <= PCO_ATTR_RST;
      end
    end
    else if (wr_strobe && aligned)
    begin
      // each slot decodes only its own index
      for (int i = 0; i < PCO_SLOTS; i++)
      begin
        if (idx == PCO_TGT_IDX[i])
          target_reg[i] <= wr_data;
        if (idx == PCO_ATTR_IDX[i])
          attr_reg[i] <= wr_data[15:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register reads, data valid the cycle after the strobe only

  always_comb
  begin
    rd_data_next = 32'h0000_0000;
    if (rd_strobe && aligned)
    begin
      for (int i = 0; i < PCO_SLOTS; i++)
      begin
        if (idx == PCO_TGT_IDX[i])
          rd_data_next = target_reg[i];
        if (idx == PCO_ATTR_IDX[i])
          rd_data_next = {16'h0000, attr_reg[i]};
      end
      if (idx == PCO_STAT_IDX)
        rd_data_next = {24'h00_0000, known_reg, above_reg};
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      rd_data_reg <= 32'h0000_0000;
    else
      rd_data_reg <= rd_data_next;
  end

  assign rd_data = rd_data_reg;

  //////////////////////////////////////////////////////////////////////////////
  // crossing detection; compares against the live target so writes act at once

  for (genvar g = 0; g < PCO_SLOTS; g++)
  begin : g_slot
    logic now_above;
    logic now_below;

    assign now_above = pos_value > target_reg[g];
    assign now_below = pos_value < target_reg[g];
    // an equal sample keeps the remembered side, so passing through the target still counts once
    assign rise_hit[g] = pos_valid && known_reg[g] && !above_reg[g] && now_above;
    assign fall_hit[g] = pos_valid && known_reg[g] && above_reg[g] && now_below;
    // only bits 0 and 1 qualify; bits 7, 8, 12, 13 and 15 (slot 0) or 14 (other slots) route the event, the rest are stored but unread here
    assign ev[g] = (rise_hit[g] && attr_reg[g][PCO_B_RISE])
                || (fall_hit[g] && attr_reg[g][PCO_B_FALL]);
    assign ev_out1[g] = ev[g] && attr_reg[g][PCO_B_OUT1];
    assign ev_out2[g] = ev[g] && attr_reg[g][PCO_B_OUT2];
    assign ev_diva[g] = ev[g] && attr_reg[g][PCO_B_DIVA];
    assign ev_divz[g] = ev[g] && attr_reg[g][PCO_B_DIVZ];
    assign ev_ocz[g]  = ev[g] && attr_reg[g][PCO_B_OCZ[g]];

    always_ff @(posedge mclk)
    begin
      if (rst)
      begin
        above_reg[g] <= 1'b0;
        known_reg[g] <= 1'b0;
      end
      else if (pos_valid && (now_above || now_below))
      begin
        // first sample after reset only learns the side, it fires nothing
        above_reg[g] <= now_above;
        known_reg[g] <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // routed outputs, one cycle pulse per event; slots share outputs by or

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      first_general_output        <= 1'b0;
      second_general_output       <= 1'b0;
      freq_div_a_output           <= 1'b0;
      freq_div_z_output           <= 1'b0;
      open_collector_index_output <= 1'b0;
    end
    else
    begin
      first_general_output        <= |ev_out1;
      second_general_output       <= |ev_out2;
      freq_div_a_output           <= |ev_diva;
      freq_div_z_output           <= |ev_divz;
      open_collector_index_output <= |ev_ocz;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  logic signed [31:0] tgt0;
  logic signed [31:0] tgt1;
  logic signed [31:0] tgt2;
  logic        [15:0] attr0;
  logic        [15:0] attr3;

  assign tgt0  = target_reg[0];
  assign tgt1  = target_reg[1];
  assign tgt2  = target_reg[2];
  assign attr0 = attr_reg[0];
  assign attr3 = attr_reg[3];

  property p_rise_out1;
    @(posedge mclk) disable iff (rst)
    pos_valid && known_reg[0] && !above_reg[0] && (pos_value > tgt0)
      && attr0[PCO_B_RISE] && attr0[PCO_B_OUT1] |=> first_general_output;
  endproperty
  a_rise_out1: assert property (p_rise_out1) else $error("rising crossing did not pulse first output");

  property p_fall_out2;
    @(posedge mclk) disable iff (rst)
    pos_valid && known_reg[3] && above_reg[3] && (pos_value < target_reg[3])
      && attr3[PCO_B_FALL] && attr3[PCO_B_OUT2] |=> second_general_output;
  endproperty
  a_fall_out2: assert property (p_fall_out2) else $error("falling crossing did not pulse second output");

  property p_out1_cause;
    @(posedge mclk) disable iff (rst)
    first_general_output |-> $past(|ev_out1);
  endproperty
  a_out1_cause: assert property (p_out1_cause) else $error("first output pulsed without routed event");

  property p_diva_cause;
    @(posedge mclk) disable iff (rst)
    !$past(rst) && !$past(|ev_diva) |-> !freq_div_a_output;
  endproperty
  a_diva_cause: assert property (p_diva_cause) else $error("divider A output pulsed without routed event");

  property p_dir_only;
    @(posedge mclk) disable iff (rst)
    ev[0] && !attr0[PCO_B_RISE] |-> fall_hit[0] && attr0[PCO_B_FALL];
  endproperty
  a_dir_only: assert property (p_dir_only) else $error("event fired without a direction bit");

  property p_tgt_reset;
    @(posedge mclk)
    $past(rst) |-> (tgt0 == 32'sh0) && (tgt2 == 32'sh0);
  endproperty
  a_tgt_reset: assert property (p_tgt_reset) else $error("target not zero after reset");

  property p_slot_indep;
    @(posedge mclk) disable iff (rst)
    wr_strobe && aligned && (idx == PCO_TGT_IDX[1]) |=> $stable(tgt2) && (tgt1 == $past(wr_data));
  endproperty
  a_slot_indep: assert property (p_slot_indep) else $error("target write not isolated to its slot");

  property p_read_next;
    @(posedge mclk) disable iff (rst)
    rd_strobe && aligned && (idx == PCO_TGT_IDX[0]) |=> rd_data == $past(tgt0)
      ##1 (rd_data == 32'h0 || $past(rd_strobe));
  endproperty
  a_read_next: assert property (p_read_next) else $error("read data wrong or held");

  property p_equal_quiet;
    @(posedge mclk) disable iff (rst)
    pos_valid && (pos_value == tgt0) |-> !rise_hit[0] && !fall_hit[0] ##1 $stable(above_reg[0]);
  endproperty
  a_equal_quiet: assert property (p_equal_quiet) else $error("equal sample counted as crossing");

  // other slots and outputs, so no single slot carries every route
  property p_fall_out1;
    @(posedge mclk) disable iff (rst)
    pos_valid && known_reg[1] && above_reg[1] && (pos_value < tgt1)
      && attr_reg[1][PCO_B_FALL] && attr_reg[1][PCO_B_OUT1] |=> first_general_output;
  endproperty
  a_fall_out1: assert property (p_fall_out1) else $error("falling crossing did not pulse first output");

  property p_rise_divz;
    @(posedge mclk) disable iff (rst)
    pos_valid && known_reg[2] && !above_reg[2] && (pos_value > tgt2)
      && attr_reg[2][PCO_B_RISE] && attr_reg[2][PCO_B_DIVZ] |=> freq_div_z_output;
  endproperty
  a_rise_divz: assert property (p_rise_divz) else $error("rising crossing did not pulse divider Z output");

  property p_out2_cause;
    @(posedge mclk) disable iff (rst)
    second_general_output |-> $past(|ev_out2);
  endproperty
  a_out2_cause: assert property (p_out2_cause) else $error("second output pulsed without routed event");

  property p_divz_cause;
    @(posedge mclk) disable iff (rst)
    !$past(rst) && !$past(|ev_divz) |-> !freq_div_z_output;
  endproperty
  a_divz_cause: assert property (p_divz_cause) else $error("divider Z output pulsed without routed event");

  property p_no_dir;
    @(posedge mclk) disable iff (rst)
    !attr_reg[1][PCO_B_RISE] && !attr_reg[1][PCO_B_FALL] |-> !ev[1];
  endproperty
  a_no_dir: assert property (p_no_dir) else $error("event fired with both direction bits clear");

  property p_first_quiet;
    @(posedge mclk) disable iff (rst)
    pos_valid && !known_reg[3] |-> !rise_hit[3] && !fall_hit[3];
  endproperty
  a_first_quiet: assert property (p_first_quiet) else $error("first sample counted as crossing");

  property p_attr_write;
    @(posedge mclk) disable iff (rst)
    wr_strobe && aligned && (idx == PCO_ATTR_IDX[0]) |=> attr0 == $past(wr_data[15:0]);
  endproperty
  a_attr_write: assert property (p_attr_write) else $error("attribute write did not act at once");

  property p_tgt_write;
    @(posedge mclk) disable iff (rst)
    wr_strobe && aligned && (idx == PCO_TGT_IDX[3]) |=> target_reg[3] == $past(wr_data);
  endproperty
  a_tgt_write: assert property (p_tgt_write) else $error("target write did not act at once");

  property p_side_learn;
    @(posedge mclk) disable iff (rst)
    pos_valid && (pos_value > tgt1) |=> above_reg[1] && known_reg[1];
  endproperty
  a_side_learn: assert property (p_side_learn) else $error("slot did not keep its own above side");

  property p_side_fall;
    @(posedge mclk) disable iff (rst)
    pos_valid && (pos_value < tgt2) |=> known_reg[2] && !above_reg[2];
  endproperty
  a_side_fall: assert property (p_side_fall) else $error("slot did not keep its own below side");

  c_rise: cover property (@(posedge mclk) disable iff (rst) rise_hit[0] && ev[0]);
  c_fall: cover property (@(posedge mclk) disable iff (rst) fall_hit[3] && ev[3]);
  c_multi: cover property (@(posedge mclk) disable iff (rst) ev[0] && ev[1]);
  c_fall_out1: cover property (@(posedge mclk) disable iff (rst) fall_hit[1] && ev_out1[1]);
  c_equal: cover property (@(posedge mclk) disable iff (rst) pos_valid && known_reg[0] && (pos_value == tgt0));

endmodule

// file: testbench/pco_compare_tb.sv
// self-checking bench for the position compare slots
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("Error t=%0t got=%h exp=%h", $time, g, e); end end
module pco_compare_tb
  import pco_pkg::*;
;
  logic                  mclk;
  logic                  rst;
  logic [PCO_ADDR_W-1:0] addr;
  logic [31:0]           wr_data;
  logic                  wr_strobe;
  logic                  rd_strobe;
  logic [31:0]           rd_data;
  logic signed [31:0]    pos_value;
  logic                  pos_valid;
  logic [4:0]            outs;
  logic [31:0]           rd_q [$];
  logic [4:0]            out_q [$];
  logic signed [31:0]    m_tgt [PCO_SLOTS];
  logic [15:0]           m_attr [PCO_SLOTS];
  logic [PCO_SLOTS-1:0]  m_known;
  logic [PCO_SLOTS-1:0]  m_above;
  logic [31:0]           seed;
  logic [31:0]           r;
  logic [31:0]           exp_rd;
  logic [4:0]            exp_out;
  logic                  rd_pend = 1'b0;
  logic                  pos_pend = 1'b0;
  int                    fails;
  int                    check_count;

  pco_compare uut (.mclk(mclk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_strobe(wr_strobe),
    .rd_strobe(rd_strobe), .rd_data(rd_data), .pos_value(pos_value), .pos_valid(pos_valid),
    .first_general_output(outs[0]), .second_general_output(outs[1]), .freq_div_a_output(outs[2]),
    .freq_div_z_output(outs[3]), .open_collector_index_output(outs[4]));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [15:0] ta(input int s);
    return {PCO_TGT_IDX[s], 2'b00};
  endfunction

  function automatic logic [15:0] aa(input int s);
    return {PCO_ATTR_IDX[s], 2'b00};
  endfunction

  // one bus or sample cycle; every input assigned once per edge
  task automatic cyc(input logic w, input logic rd, input logic v, input logic [15:0] a, input logic [31:0] d,
                     input logic [31:0] p);
    wr_strobe <= w;
    rd_strobe <= rd;
    pos_valid <= v;
    addr <= a;
    wr_data <= d;
    pos_value <= p;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    for (int s = 0; s < PCO_SLOTS; s++)
    begin
      if (a == ta(s)) m_tgt[s] = d;
      if (a == aa(s)) m_attr[s] = d[15:0];
    end
    cyc(1'b1, 1'b0, 1'b0, a, d, 32'h0);
  endtask

  task automatic rd(input logic [15:0] a);
    logic [31:0] e;
    e = 32'h0;
    for (int s = 0; s < PCO_SLOTS; s++)
    begin
      if (a == ta(s)) e = m_tgt[s];
      if (a == aa(s)) e = {16'h0000, m_attr[s]};
    end
    if (a == {PCO_STAT_IDX, 2'b00}) e = {24'h00_0000, m_known, m_above};
    rd_q.push_back(e);
    cyc(1'b0, 1'b1, 1'b0, a, 32'h0, 32'h0);
  endtask

  // equal sample keeps the remembered side, so below-equal-above fires once
  task automatic pos(input logic signed [31:0] p);
    logic [4:0] e;
    e = 5'h00;
    for (int s = 0; s < PCO_SLOTS; s++)
      if (p != m_tgt[s])
      begin
        if (m_known[s] && ((p > m_tgt[s]) ? (!m_above[s] && m_attr[s][PCO_B_RISE])
                                          : (m_above[s] && m_attr[s][PCO_B_FALL])))
          e = e | {m_attr[s][PCO_B_OCZ[s]], m_attr[s][PCO_B_DIVZ], m_attr[s][PCO_B_DIVA], m_attr[s][PCO_B_OUT2],
                   m_attr[s][PCO_B_OUT1]};
        m_known[s] = 1'b1;
        m_above[s] = p > m_tgt[s];
      end
    out_q.push_back(e);
    cyc(1'b0, 1'b0, 1'b1, 16'h0000, 32'h0, p);
  endtask

  task automatic wrap_up();
    if (fails == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk)
  begin
    exp_rd = rd_pend ? rd_q.pop_front() : 32'h0;
    exp_out = pos_pend ? out_q.pop_front() : 5'h00;
    if (!rst) `CHK(rd_data, exp_rd)
    if (!rst) `CHK(outs, exp_out)
    rd_pend <= rd_strobe && !rst;
    pos_pend <= pos_valid && !rst;
  end

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  initial
  begin
    repeat (4000) @(posedge mclk);
    fails++;
    wrap_up();
  end

  initial
  begin
    rst = 1'b1;
    {wr_strobe, rd_strobe, pos_valid, addr, wr_data, pos_value, fails, check_count} = '0;
    {m_known, m_above} = '0;
    seed = 32'h4;
    for (int s = 0; s < PCO_SLOTS; s++) {m_tgt[s], m_attr[s]} = '0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    cyc(1'b0, 1'b0, 1'b0, 16'h0000, 32'h0, 32'h0);
    for (int s = 0; s < PCO_SLOTS; s++) rd(ta(s));
    for (int s = 0; s < PCO_SLOTS; s++) rd(aa(s));
    rd(16'h0000);
    wr(aa(0) | 16'h0001, 32'hffff);
    rd(aa(0));
    wr(ta(1), 32'h8000_0000);
    rd(ta(1));
    wr(ta(2), 32'h7fff_ffff);
    rd(ta(2));
    wr(ta(3), 32'h7fff_fffe);
    wr(aa(3), 32'h1181);
    pos(32'h7fff_fffd);
    pos(32'h7fff_fffe);
    pos(32'h7fff_ffff);
    // small spans keep targets and samples close so crossings are frequent
    repeat (400)
    begin
      r = xs();
      case (r[2:0])
        3'h0: wr(ta(r[9:8]), {{28{r[7]}}, r[7:4]});
        3'h1: wr(aa(r[9:8]), {r[15:0], r[31:16]});
        3'h2: rd(r[4] ? {PCO_STAT_IDX, 2'b00} : r[3] ? ta(r[9:8]) : aa(r[9:8]));
        default: pos({{28{r[15]}}, r[15:12]});
      endcase
    end
    repeat (4) cyc(1'b0, 1'b0, 1'b0, 16'h0000, 32'h0, 32'h0);
    // second reset in mid-run; the model forgets everything with the design
    rst <= 1'b1;
    repeat (2) cyc(1'b0, 1'b0, 1'b0, 16'h0000, 32'h0, 32'h0);
    rst <= 1'b0;
    for (int s = 0; s < PCO_SLOTS; s++) {m_tgt[s], m_attr[s]} = '0;
    {m_known, m_above} = '0;
    cyc(1'b0, 1'b0, 1'b0, 16'h0000, 32'h0, 32'h0);
    for (int s = 0; s < PCO_SLOTS; s++) rd(ta(s));
    rd(aa(3));
    pos(32'h0000_0005);
    rd({PCO_STAT_IDX, 2'b00});
    rd(aa(3) | 16'h0002);
    repeat (4) cyc(1'b0, 1'b0, 1'b0, 16'h0000, 32'h0, 32'h0);
    wrap_up();
  end
endmodule
